// [core/rtcal_core.sv]
// rtc calendar, alarm, carry and periodic interrupt logic
// ****************************************
// ****************************************
`timescale 1ns/10ps
`default_nettype none
module rtcal_core #(
    parameter int DIV = rtcal_pkg::PRESCALE_DEFAULT
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output var rtcal_pkg::rtcal_irq_t irq_out
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [4:0] month_days(input logic [3:0] m, input logic [13:0] y);
        if (m == rtcal_pkg::MON_FEB) begin
            month_days = (y[1:0] == 2'h0) ? 5'h1d : 5'h1c;
        end else begin
            month_days = rtcal_pkg::LONG_MONTHS[m - rtcal_pkg::MON_FIRST] ? 5'h1f : 5'h1e;
        end
    endfunction
    // interval as a power of two of 256 hz steps, codes 1..7
    function automatic logic per_hit(input logic [2:0] s, input logic [8:0] n);
        logic [8:0] m;
        m = 9'h000;
        unique case (s)
            3'h1: m = 9'h000;
            3'h2: m = 9'h003;
            3'h3: m = 9'h00f;
            3'h4: m = 9'h03f;
            3'h5: m = 9'h07f;
            3'h6: m = 9'h0ff;
            3'h7: m = 9'h1ff;
            default: m = 9'h000;
        endcase
        per_hit = (s != rtcal_pkg::PES_OFF) && ((n & m) == 9'h000);
    endfunction
    function automatic logic fld_ok(input logic [7:0] a, input logic [6:0] v);
        fld_ok = !a[rtcal_pkg::B_AEN] || (a[6:0] == v);
    endfunction
    // ****************************************
    // state
    // ****************************************
    rtcal_pkg::rtcal_time_t tm_reg;
    rtcal_pkg::rtcal_time_t tm_next;
    logic [7:0] alm_reg [rtcal_pkg::ALM_N];
    logic [16:0] yalm_reg;
    logic cf_reg, cf_next, af_reg, af_next, pef_reg, pef_next;
    logic cie_reg, aie_reg, osc_reg, start_reg;
    logic [2:0] pes_reg;
    logic div_clr_reg;
    logic tick;
    logic [8:0] sub;
    // ****************************************
    // decode
    // ****************************************
    wire wr_ctl1 = wr_in && (addr_in == rtcal_pkg::OFS_CTL1);
    wire wr_ctl2 = wr_in && (addr_in == rtcal_pkg::OFS_CTL2);
    // steps counted after the increment, so a divider restart gives full intervals
    wire sec_tick = tick && (sub[7:0] == 8'h00);
    wire cal_step = sec_tick && start_reg;
    wire per_evt = tick && per_hit(pes_reg, sub);
    wire any_en = alm_reg[0][rtcal_pkg::B_AEN] || alm_reg[1][rtcal_pkg::B_AEN]
        || alm_reg[2][rtcal_pkg::B_AEN] || alm_reg[3][rtcal_pkg::B_AEN]
        || alm_reg[4][rtcal_pkg::B_AEN] || alm_reg[5][rtcal_pkg::B_AEN]
        || yalm_reg[rtcal_pkg::B_YEN];
    wire match = any_en
        && fld_ok(alm_reg[0], {1'b0, tm_reg.sec})
        && fld_ok(alm_reg[1], {1'b0, tm_reg.min})
        && fld_ok(alm_reg[2], {2'h0, tm_reg.hour})
        && fld_ok(alm_reg[3], {4'h0, tm_reg.wday})
        && fld_ok(alm_reg[4], {2'h0, tm_reg.day})
        && fld_ok(alm_reg[5], {3'h0, tm_reg.mon})
        && (!yalm_reg[rtcal_pkg::B_YEN] || (yalm_reg[13:0] == tm_reg.year));
    // ****************************************
    // divider
    // ****************************************
    rtcal_divider #(
        .DIV(DIV)
    ) u_div (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .run_in(osc_reg),
        .clear_in(div_clr_reg),
        .tick_out(tick),
        .sub_out(sub)
    );
    // ****************************************
    // calendar
    // ****************************************
    // a write in a carry cycle wins for its own field only, so the rest
    // of the step still lands; software sees the carry flag and retries
    always_comb begin
        tm_next = tm_reg;
        if (cal_step) begin
            tm_next.sec = tm_reg.sec + 6'h01;
            if (tm_reg.sec == rtcal_pkg::SEC_MAX) begin
                tm_next.sec = '0;
                tm_next.min = tm_reg.min + 6'h01;
                if (tm_reg.min == rtcal_pkg::MIN_MAX) begin
                    tm_next.min = '0;
                    tm_next.hour = tm_reg.hour + 5'h01;
                    if (tm_reg.hour == rtcal_pkg::HOUR_MAX) begin
                        tm_next.hour = '0;
                        tm_next.wday = tm_reg.wday + 3'h1;
                        if (tm_reg.wday >= rtcal_pkg::WDAY_MAX) begin
                            tm_next.wday = '0;
                        end
                        tm_next.day = tm_reg.day + 5'h01;
                        if (tm_reg.day >= month_days(tm_reg.mon, tm_reg.year)) begin
                            tm_next.day = rtcal_pkg::DAY_FIRST;
                            tm_next.mon = tm_reg.mon + 4'h1;
                            if (tm_reg.mon >= rtcal_pkg::MON_MAX) begin
                                tm_next.mon = rtcal_pkg::MON_FIRST;
                                tm_next.year = tm_reg.year + 14'h0001;
                                if (tm_reg.year >= rtcal_pkg::YEAR_MAX) begin
                                    tm_next.year = '0;
                                end
                            end
                        end
                    end
                end
            end
        end
        if (wr_in) begin
            unique case (addr_in)
                rtcal_pkg::OFS_SEC: tm_next.sec = wdata_in[5:0];
                rtcal_pkg::OFS_MIN: tm_next.min = wdata_in[5:0];
                rtcal_pkg::OFS_HOUR: tm_next.hour = wdata_in[4:0];
                rtcal_pkg::OFS_WDAY: tm_next.wday = wdata_in[2:0];
                rtcal_pkg::OFS_DAY: tm_next.day = wdata_in[4:0];
                rtcal_pkg::OFS_MON: tm_next.mon = wdata_in[3:0];
                rtcal_pkg::OFS_YEAR: tm_next.year = wdata_in[13:0];
                default: tm_next = tm_next;
            endcase
        end
    end
    // ****************************************
    // flags: hardware set beats software clear
    // ****************************************
    always_comb begin
        cf_next = cf_reg;
        af_next = af_reg;
        pef_next = pef_reg;
        if (wr_ctl1 && !wdata_in[rtcal_pkg::B_CF]) begin
            cf_next = 1'b0;
        end
        if (wr_ctl1 && !wdata_in[rtcal_pkg::B_AF]) begin
            af_next = 1'b0;
        end
        if (wr_ctl2) begin
            pef_next = wdata_in[rtcal_pkg::B_PEF];
        end
        if (cal_step) begin
            cf_next = 1'b1;
        end
        if (match) begin
            af_next = 1'b1;
        end
        if (per_evt) begin
            pef_next = 1'b1;
        end
    end
    // ****************************************
    // register file
    // ****************************************
    wire [31:0] rd_mux =
        (addr_in == rtcal_pkg::OFS_CTL1) ? 32'({cf_reg, 2'h0, cie_reg, aie_reg, 2'h0, af_reg}) :
        (addr_in == rtcal_pkg::OFS_CTL2) ? 32'({pef_reg, pes_reg, osc_reg, 2'h0, start_reg}) :
        (addr_in == rtcal_pkg::OFS_C64) ? 32'(sub[7:1]) :
        (addr_in == rtcal_pkg::OFS_SEC) ? 32'(tm_reg.sec) :
        (addr_in == rtcal_pkg::OFS_MIN) ? 32'(tm_reg.min) :
        (addr_in == rtcal_pkg::OFS_HOUR) ? 32'(tm_reg.hour) :
        (addr_in == rtcal_pkg::OFS_WDAY) ? 32'(tm_reg.wday) :
        (addr_in == rtcal_pkg::OFS_DAY) ? 32'(tm_reg.day) :
        (addr_in == rtcal_pkg::OFS_MON) ? 32'(tm_reg.mon) :
        (addr_in == rtcal_pkg::OFS_YEAR) ? 32'(tm_reg.year) :
        (addr_in == rtcal_pkg::OFS_YALM) ? 32'(yalm_reg) :
        (addr_in[7:2] >= rtcal_pkg::OFS_ALM0[7:2]) && (addr_in[7:2] <
            6'(rtcal_pkg::OFS_ALM0[7:2] + 6'(rtcal_pkg::ALM_N))) ?
            32'(alm_reg[3'(addr_in[7:2] - rtcal_pkg::OFS_ALM0[7:2])]) : 32'h0000_0000;
    wire alm_hit = wr_in && (addr_in[7:2] >= rtcal_pkg::OFS_ALM0[7:2])
        && (addr_in[7:2] < 6'(rtcal_pkg::OFS_ALM0[7:2] + 6'(rtcal_pkg::ALM_N)));
    wire [2:0] alm_idx = 3'(addr_in[7:2] - rtcal_pkg::OFS_ALM0[7:2]);
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tm_reg <= '{year: '0, mon: rtcal_pkg::MON_FIRST, day: rtcal_pkg::DAY_FIRST,
                wday: '0, hour: '0, min: '0, sec: '0};
            cf_reg <= 1'b0;
            af_reg <= 1'b0;
            pef_reg <= 1'b0;
            cie_reg <= 1'b0;
            aie_reg <= 1'b0;
            pes_reg <= rtcal_pkg::CTL2_RESET[rtcal_pkg::B_PES +: 3];
            osc_reg <= rtcal_pkg::CTL2_RESET[rtcal_pkg::B_OSC];
            start_reg <= rtcal_pkg::CTL2_RESET[rtcal_pkg::B_START];
            div_clr_reg <= 1'b0;
            yalm_reg <= '0;
            rdata_out <= '0;
            irq_out <= '0;
        end else begin
            tm_reg <= tm_next;
            cf_reg <= cf_next;
            af_reg <= af_next;
            pef_reg <= pef_next;
            // one-cycle pulse; the bit never holds a 1
            div_clr_reg <= wr_ctl2 && wdata_in[rtcal_pkg::B_DRST];
            if (wr_ctl1) begin
                cie_reg <= wdata_in[rtcal_pkg::B_CIE];
                aie_reg <= wdata_in[rtcal_pkg::B_AIE];
            end
            if (wr_ctl2) begin
                pes_reg <= wdata_in[rtcal_pkg::B_PES +: 3];
                osc_reg <= wdata_in[rtcal_pkg::B_OSC];
                start_reg <= wdata_in[rtcal_pkg::B_START];
            end
            if (wr_in && (addr_in == rtcal_pkg::OFS_YALM)) begin
                yalm_reg <= wdata_in[16:0];
            end
            rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
            // fed from next values so each irq tracks its flag in step
            irq_out.alarm <= af_next && aie_reg_next();
            irq_out.periodic <= pef_next && (pes_next() != rtcal_pkg::PES_OFF);
            irq_out.carry <= cf_next && cie_reg_next();
        end
    end
    function automatic logic aie_reg_next();
        aie_reg_next = wr_ctl1 ? wdata_in[rtcal_pkg::B_AIE] : aie_reg;
    endfunction
    function automatic logic cie_reg_next();
        cie_reg_next = wr_ctl1 ? wdata_in[rtcal_pkg::B_CIE] : cie_reg;
    endfunction
    function automatic logic [2:0] pes_next();
        pes_next = wr_ctl2 ? wdata_in[rtcal_pkg::B_PES +: 3] : pes_reg;
    endfunction
    // alarm words reset to disabled so nothing fires before setup
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < rtcal_pkg::ALM_N; i++) begin
                alm_reg[i] <= 8'h00;
            end
        end else if (alm_hit) begin
            alm_reg[alm_idx] <= wdata_in[7:0];
        end
    end
    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    property p_alarm_irq;
        irq_out.alarm == (af_reg && aie_reg);
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm irq wrong");
    property p_per_irq;
        irq_out.periodic == (pef_reg && (pes_reg != rtcal_pkg::PES_OFF));
    endproperty
    a_per_irq: assert property (p_per_irq) else $error("periodic irq wrong");
    property p_carry_irq;
        irq_out.carry == (cf_reg && cie_reg);
    endproperty
    a_carry_irq: assert property (p_carry_irq) else $error("carry irq wrong");
    property p_match_sets;
        match |=> af_reg;
    endproperty
    a_match_sets: assert property (p_match_sets) else $error("alarm flag missed");
    property p_match_holds;
        match && wr_ctl1 && !wdata_in[rtcal_pkg::B_AF] |=> af_reg;
    endproperty
    a_match_holds: assert property (p_match_holds) else $error("alarm flag lost");
    property p_none_enabled;
        $rose(af_reg) |-> $past(match);
    endproperty
    a_none_enabled: assert property (p_none_enabled) else $error("alarm flag without match");
    property p_per_evt;
        per_evt |=> pef_reg;
    endproperty
    a_per_evt: assert property (p_per_evt) else $error("periodic flag missed");
    property p_div_clr;
        wr_ctl2 && wdata_in[rtcal_pkg::B_DRST] |=> ##1 (sub == 9'h000) && !div_clr_reg;
    endproperty
    a_div_clr: assert property (p_div_clr) else $error("divider not reset");
    property p_stopped;
        !start_reg && !wr_in |=> $stable(tm_reg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("calendar ran while stopped");
    property p_write_own;
        wr_in && (addr_in == rtcal_pkg::OFS_SEC) && !cal_step |=>
            (tm_reg.sec == $past(wdata_in[5:0])) && (tm_reg.min == $past(tm_reg.min));
    endproperty
    a_write_own: assert property (p_write_own) else $error("write spilled");
    // flags are sticky, so the carry and alarm clears are checked apart from their sets
    property p_carry_sets;
        cal_step |=> cf_reg;
    endproperty
    a_carry_sets: assert property (p_carry_sets) else $error("carry flag missed");
    property p_cf_clear;
        wr_ctl1 && !wdata_in[rtcal_pkg::B_CF] && !cal_step |=> !cf_reg;
    endproperty
    a_cf_clear: assert property (p_cf_clear) else $error("carry flag not cleared");
    property p_af_clear;
        wr_ctl1 && !wdata_in[rtcal_pkg::B_AF] && !match |=> !af_reg;
    endproperty
    a_af_clear: assert property (p_af_clear) else $error("alarm flag not cleared");
    property p_pef_write;
        wr_ctl2 && wdata_in[rtcal_pkg::B_PEF] |=> pef_reg;
    endproperty
    a_pef_write: assert property (p_pef_write) else $error("periodic flag not set");
    property p_rdata_idle;
        !rd_in |=> (rdata_out == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
    c_alarm: cover property (match ##1 irq_out.alarm);
    c_carry: cover property (cal_step ##1 cf_reg);
    c_periodic: cover property (per_evt ##1 irq_out.periodic);
    c_alarm_kept: cover property (match && wr_ctl1 && !wdata_in[rtcal_pkg::B_AF] ##1 af_reg);
    c_restart: cover property (div_clr_reg ##1 (sub == 9'h000));
endmodule
`default_nettype wire

// [core/rtcal_divider.sv]
// prescaler and sub-second counter of the rtc
`timescale 1ns/10ps
`default_nettype none
module rtcal_divider #(
    parameter int DIV = rtcal_pkg::PRESCALE_DEFAULT
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input wire logic clear_in,
    output logic tick_out,
    output logic [rtcal_pkg::SUB_W-1:0] sub_out
);
    // ****************************************
    // prescaler down to the 256 hz step
    // ****************************************
    localparam logic [rtcal_pkg::PRE_W-1:0] PRE_LAST = rtcal_pkg::PRE_W'(DIV - 1);
    logic [rtcal_pkg::PRE_W-1:0] pre_reg;
    logic [rtcal_pkg::PRE_W-1:0] pre_next;
    logic [rtcal_pkg::SUB_W-1:0] sub_next;
    logic tick_next;
    wire pre_wrap = run_in && (pre_reg == PRE_LAST);
    // halted oscillator freezes everything but a clear, which still zeroes both counters; clear wins over a running step
    always_comb begin
        pre_next = pre_reg;
        sub_next = sub_out;
        tick_next = 1'b0;
        if (clear_in) begin
            pre_next = '0;
            sub_next = '0;
        end else if (pre_wrap) begin
            pre_next = '0;
            sub_next = sub_out + rtcal_pkg::SUB_W'(1);
            tick_next = 1'b1;
        end else if (run_in) begin
            pre_next = pre_reg + rtcal_pkg::PRE_W'(1);
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pre_reg <= '0;
            sub_out <= '0;
            tick_out <= 1'b0;
        end else begin
            pre_reg <= pre_next;
            sub_out <= sub_next;
            tick_out <= tick_next;
        end
    end
endmodule
`default_nettype wire

// [core/rtcal_pkg.sv]
// shared constants and types of the rtc alarm and interrupt block
package rtcal_pkg;
    // ****************************************
    // clocking
    // ****************************************
    localparam int CLK_HZ = 50000000;
    localparam int TICK_HZ = 256;
    localparam int PRESCALE_DEFAULT = CLK_HZ / TICK_HZ;
    localparam int PRE_W = 18;
    localparam int SUB_W = 9;
    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CTL1 = 8'h00;
    localparam logic [7:0] OFS_CTL2 = 8'h04;
    localparam logic [7:0] OFS_C64 = 8'h08;
    localparam logic [7:0] OFS_SEC = 8'h0c;
    localparam logic [7:0] OFS_MIN = 8'h10;
    localparam logic [7:0] OFS_HOUR = 8'h14;
    localparam logic [7:0] OFS_WDAY = 8'h18;
    localparam logic [7:0] OFS_DAY = 8'h1c;
    localparam logic [7:0] OFS_MON = 8'h20;
    localparam logic [7:0] OFS_YEAR = 8'h24;
    localparam logic [7:0] OFS_ALM0 = 8'h28;
    localparam logic [7:0] OFS_YALM = 8'h40;
    localparam int ALM_N = 6;
    // ****************************************
    // field positions
    // ****************************************
    localparam int B_CF = 7;
    localparam int B_CIE = 4;
    localparam int B_AIE = 3;
    localparam int B_AF = 0;
    localparam int B_PEF = 7;
    localparam int B_PES = 4;
    localparam int B_OSC = 3;
    localparam int B_DRST = 1;
    localparam int B_START = 0;
    localparam int B_AEN = 7;
    localparam int B_YEN = 16;
    localparam logic [2:0] PES_OFF = 3'h0;
    localparam logic [7:0] CTL2_RESET = 8'h09;
    // ****************************************
    // calendar limits and reset values
    // ****************************************
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] WDAY_MAX = 3'h6;
    localparam logic [3:0] MON_MAX = 4'hc;
    localparam logic [13:0] YEAR_MAX = 14'h270f;
    localparam logic [4:0] DAY_FIRST = 5'h01;
    localparam logic [3:0] MON_FIRST = 4'h1;
    localparam logic [3:0] MON_FEB = 4'h2;
    localparam logic [11:0] LONG_MONTHS = 12'had5;
    typedef struct packed {
        logic [13:0] year;
        logic [3:0] mon;
        logic [4:0] day;
        logic [2:0] wday;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
    } rtcal_time_t;
    typedef struct packed {
        logic alarm;
        logic periodic;
        logic carry;
    } rtcal_irq_t;
endpackage

// [tb/test_rtcal_core.sv]
// self-checking testbench of the rtc alarm, carry and periodic interrupt block
`timescale 1ns/10ps
`default_nettype none
module test_rtcal_core;
    // ****************************************
    // clock, reset and design under test
    // ****************************************
    // small divider keeps one second at 256 * 4 clocks
    localparam int DIV_SIM = 4;
    logic clk_in;
    logic rst_in;
    logic [7:0] addr_in;
    logic [31:0] wdata_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rdata_out;
    rtcal_pkg::rtcal_irq_t irq_out;
    int bad_count = 0;
    int tests_run = 0;
    logic [31:0] seed = 32'h0000004a;
    int model [0:6];
    int lim [0:6] = '{60, 59, 24, 7, 28, 12, 10000};
    int base [0:6] = '{0, 0, 0, 0, 1, 1, 0};
    logic [31:0] v;
    logic [31:0] v2;

    rtcal_core #(.DIV(DIV_SIM)) rtcal_core_inst (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .wr_in(wr_in),
        .rd_in(rd_in),
        .rdata_out(rdata_out),
        .irq_out(irq_out)
    );

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // ****************************************
    // helpers
    // ****************************************
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // strobe dropped at the taking edge; #1 lets that edge's updates land
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
        @(posedge clk_in);
        #1;
        chk("rdata_idle", rdata_out, 32'h0);
    endtask

    task final_report();
        if (bad_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        repeat (60000) @(posedge clk_in);
        bad_count++;
        final_report();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_in = 1'b1;
        addr_in = 8'h00;
        wdata_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        repeat (5) @(posedge clk_in);
        rst_in <= 1'b0;
        // reset values and an unmapped place
        rd(rtcal_pkg::OFS_CTL2, v);
        chk("ctl2_rst", v, {24'h0, rtcal_pkg::CTL2_RESET});
        rd(rtcal_pkg::OFS_CTL1, v);
        chk("ctl1_rst", v, 32'h0);
        rd(rtcal_pkg::OFS_DAY, v);
        chk("day_rst", v, 32'h1);
        rd(8'hfc, v);
        chk("unmapped", v, 32'h0);
        // stopped calendar, random counters, each write hits only its target
        wr(rtcal_pkg::OFS_CTL2, 32'h08);
        for (int i = 0; i < 7; i++) begin
            model[i] = int'(xs() % 32'(lim[i])) + base[i];
            wr(rtcal_pkg::OFS_SEC + 8'(4 * i), 32'(model[i]));
        end
        for (int i = 0; i < 7; i++) begin
            rd(rtcal_pkg::OFS_SEC + 8'(4 * i), v);
            chk("counter", v, 32'(model[i]));
        end
        // sub-second counter keeps going while calendar is stopped
        rd(rtcal_pkg::OFS_C64, v);
        repeat (8 * DIV_SIM) @(posedge clk_in);
        rd(rtcal_pkg::OFS_C64, v2);
        chk("c64_moves", 32'(v !== v2), 32'h1);
        rd(rtcal_pkg::OFS_SEC, v);
        chk("sec_held", v, 32'(model[0]));
        // alarm: one enabled field off, then all enabled fields equal
        // minute first: a lone matching second alarm would set the flag early
        wr(rtcal_pkg::OFS_ALM0 + 8'h04, 32'h80 | 32'((model[1] + 1) % 60));
        wr(rtcal_pkg::OFS_ALM0, 32'h80 | 32'(model[0]));
        repeat (3) @(posedge clk_in);
        rd(rtcal_pkg::OFS_CTL1, v);
        chk("af_partial", v, 32'h0);
        wr(rtcal_pkg::OFS_ALM0 + 8'h04, 32'h80 | 32'(model[1]));
        repeat (2) @(posedge clk_in);
        rd(rtcal_pkg::OFS_CTL1, v);
        chk("af_match", v, 32'h1);
        chk("irq_alarm_off", {31'h0, irq_out.alarm}, 32'h0);
        wr(rtcal_pkg::OFS_CTL1, 32'h09);
        chk("irq_alarm_on", {31'h0, irq_out.alarm}, 32'h1);
        chk("irq_sep", {29'h0, irq_out}, 32'h4);
        wr(rtcal_pkg::OFS_CTL1, 32'h08);
        @(posedge clk_in);
        rd(rtcal_pkg::OFS_CTL1, v);
        chk("af_resets", v, 32'h09);
        // year field joins and breaks the match
        wr(rtcal_pkg::OFS_YALM, 32'h10000 | 32'((model[6] + 1) % 10000));
        repeat (2) @(posedge clk_in);
        wr(rtcal_pkg::OFS_CTL1, 32'h08);
        repeat (2) @(posedge clk_in);
        rd(rtcal_pkg::OFS_CTL1, v);
        chk("af_year", v, 32'h08);
        chk("irq_alarm_drop", {31'h0, irq_out.alarm}, 32'h0);
        wr(rtcal_pkg::OFS_YALM, 32'h0);
        wr(rtcal_pkg::OFS_ALM0, 32'h0);
        wr(rtcal_pkg::OFS_ALM0 + 8'h04, 32'h0);
        // carry: 59 s rolls over one second after a divider restart
        model[0] = 59;
        wr(rtcal_pkg::OFS_SEC, 32'(model[0]));
        wr(rtcal_pkg::OFS_CTL1, 32'h10);
        wr(rtcal_pkg::OFS_CTL2, 32'h0b);
        rd(rtcal_pkg::OFS_CTL2, v);
        chk("drst_clears", v, 32'h09);
        // first second after a restart is a full 256 steps
        repeat (256 * DIV_SIM - 2) @(posedge clk_in);
        #1;
        chk("irq_carry_early", {31'h0, irq_out.carry}, 32'h0);
        @(posedge clk_in);
        #1;
        chk("irq_carry", {31'h0, irq_out.carry}, 32'h1);
        rd(rtcal_pkg::OFS_CTL1, v);
        chk("cf_set", v, 32'h90);
        rd(rtcal_pkg::OFS_SEC, v);
        chk("sec_wrap", v, 32'h0);
        rd(rtcal_pkg::OFS_MIN, v);
        chk("min_step", v, 32'(model[1] + 1));
        wr(rtcal_pkg::OFS_CTL1, 32'h10);
        chk("irq_carry_drop", {31'h0, irq_out.carry}, 32'h0);
        // periodic: flag set by write, no request while select is zero
        wr(rtcal_pkg::OFS_CTL2, 32'h88);
        rd(rtcal_pkg::OFS_CTL2, v);
        chk("pef_write", v, 32'h88);
        chk("irq_per_off", {31'h0, irq_out.periodic}, 32'h0);
        // every interval code, timed from a divider restart
        for (int code = 1; code < 8; code++) begin
            int k;
            k = (code == 1) ? 0 : (code < 5) ? 2 * code - 2 : code + 2;
            // restart, then clear the flag once the restart has landed
            wr(rtcal_pkg::OFS_CTL2, 32'(code << 4) | 32'h0a);
            wr(rtcal_pkg::OFS_CTL2, 32'(code << 4) | 32'h08);
            chk("irq_per_clr", {31'h0, irq_out.periodic}, 32'h0);
            repeat (DIV_SIM * (1 << k) - 1) @(posedge clk_in);
            #1;
            chk("irq_per_early", {31'h0, irq_out.periodic}, 32'h0);
            @(posedge clk_in);
            #1;
            chk("irq_per", {31'h0, irq_out.periodic}, 32'h1);
            rd(rtcal_pkg::OFS_CTL2, v);
            chk("pef_interval", v, 32'h88 | 32'(code << 4));
        end
        final_report();
    end
endmodule
`default_nettype wire
